/* pkg/motor_bank_pkg.sv */
// Shared constants and types of the motor driver register bank
package motor_bank_pkg;

	// ************************************************************
	// Register locations
	// ************************************************************
	localparam int         NUM_REGS        = 16;
	localparam logic [3:0] ADDR_STATUS     = 4'h0;
	localparam logic [3:0] ADDR_RETRACT    = 4'h1;
	localparam logic [3:0] ADDR_CALIB      = 4'h2;
	localparam logic [3:0] ADDR_MOTOR      = 4'h3;
	localparam logic [3:0] ADDR_SPINDLE    = 4'h4;
	localparam logic [3:0] ADDR_ENABLES    = 4'h5;
	localparam logic [3:0] ADDR_PRESCALE   = 4'h6;
	localparam logic [3:0] ADDR_TORQUE     = 4'h7;
	localparam logic [3:0] ADDR_SPEED      = 4'h8;
	localparam logic [3:0] ADDR_CMD_HIGH   = 4'h9;
	localparam logic [3:0] ADDR_CMD_LOW    = 4'ha;
	localparam logic [3:0] ADDR_ADC_HIGH   = 4'hb;
	localparam logic [3:0] ADDR_ADC_CTRL   = 4'hc;
	localparam logic [3:0] ADDR_SPARE_A    = 4'hd;
	localparam logic [3:0] ADDR_SPARE_B    = 4'he;
	localparam logic [3:0] ADDR_TEST       = 4'hf;
	localparam logic [7:0] REG_RESET       = 8'h00;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int STAT_WARN_BIT    = 3;
	localparam int STAT_TRIP_BIT    = 4;
	localparam int STAT_FAULT_BIT   = 5;
	localparam int STAT_CAL_BIT     = 6;
	localparam int STAT_POL_BIT     = 7;
	localparam int RU_BRAKE_BIT     = 0;
	localparam int RU_THRESH_LSB    = 1;
	localparam int RU_LEVEL2_LSB    = 4;
	localparam int RU_LEVEL1_LSB    = 6;
	localparam int RC_TRIM_LSB      = 0;
	localparam int RC_UPPER_LSB     = 4;
	localparam int MS_VCM_LSB       = 4;
	localparam int EP_EDGE_BIT      = 7;
	localparam int CC_CTRL_WIDTH    = 6;

	// ************************************************************
	// Field codes
	// ************************************************************
	localparam logic [2:0] VCM_STATE_CAL   = 3'h5;
	localparam logic [2:0] THRESH_ONLY_ONE = 3'h0;
	localparam logic [2:0] THRESH_ONLY_TWO = 3'h7;

	// ************************************************************
	// Serial frame counts and identity
	// ************************************************************
	localparam logic [4:0] HDR_LAST_EDGE   = 5'h07;
	localparam logic [4:0] FRAME_LAST_EDGE = 5'h0f;
	localparam logic [4:0] FRAME_EDGES     = 5'h10;
	localparam logic [2:0] REVISION_DEF    = 3'h1; // Arbitrary value
	localparam logic [2:0] CHIP_ID_DEF     = 3'h5; // Arbitrary value
	localparam int         SYNC_WIDTH      = 16;

	// Phase of a serial frame
	typedef enum logic [1:0] {
		PH_HEADER = 2'b00,
		PH_WRITE  = 2'b01,
		PH_READ   = 2'b10,
		PH_DONE   = 2'b11
	} link_phase_e;

endpackage

/* core/bit_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module bit_sync
	import motor_bank_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rstn,
	// Foreign-domain level
	input  wire logic [WIDTH-1:0] i_async,
	// Level in the local domain
	output logic      [WIDTH-1:0] o_sync
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] held;
	} sync_s;

	sync_s st_r;
	sync_s st_nxt;

	// First stage feeds only the second stage
	always_comb begin
		st_nxt.meta = i_async;
		st_nxt.held = st_r.meta;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_sync = st_r.held;

endmodule

/* core/serial_turnaround.sv */
// Half-cycle late output enable for the shared serial data pin
`timescale 1ns/1ps
module serial_turnaround
	import motor_bank_pkg::*;
(
	// Link sample clock and frame reset
	input  wire logic i_link_clk,
	input  wire logic i_frame_rstn,
	// Request to own the data pin
	input  wire logic i_drive_req,
	// Pin enable
	output logic      o_drive_en
);

	typedef struct packed {
		logic drive;
	} turn_s;

	turn_s st_r;
	turn_s st_nxt;

	// Take the pin on the edge opposite to sampling, so the host
	// has released it after its last address bit
	always_comb begin
		st_nxt.drive = i_drive_req;
	end

	always_ff @(negedge i_link_clk or negedge i_frame_rstn) begin
		if (!i_frame_rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_drive_en = st_r.drive;

endmodule

/* core/motor_driver_register_bank.sv */
// Serial-port register bank of the spindle and voice-coil driver
`timescale 1ns/1ps
module motor_driver_register_bank
	import motor_bank_pkg::*;
#(
	parameter logic [2:0] REVISION = REVISION_DEF, // Arbitrary value
	parameter logic [2:0] CHIP_ID  = CHIP_ID_DEF   // Arbitrary value
) (
	// Core clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	// Serial link
	input  wire logic        i_serial_clk,
	input  wire logic        i_serial_select_n,
	input  wire logic        i_serial_io,
	output logic             o_serial_io,
	output logic             o_serial_io_oe,
	// Detector and converter inputs
	input  wire logic        i_thermal_warning_flag,
	input  wire logic        i_thermal_trip_flag,
	input  wire logic        i_speed_sync_fault,
	input  wire logic        i_coil_cal_comparator,
	input  wire logic        i_spindle_current_polarity,
	input  wire logic [9:0]  i_adc_result,
	// Retract and unload controls
	output logic             o_active_brake_disable,
	output logic [2:0]       o_unload_phase_threshold,
	output logic             o_unload_phase_one,
	output logic             o_unload_phase_two,
	output logic [1:0]       o_phase_two_unload_level,
	output logic [1:0]       o_phase_one_unload_level,
	output logic [3:0]       o_retract_trim,
	output logic [3:0]       o_calib_shock_upper,
	// Motor and control registers
	output logic [7:0]       o_motor_state_select,
	output logic [7:0]       o_spindle_drive_control,
	output logic [7:0]       o_enables_and_protocol,
	output logic [7:0]       o_clock_prescale_window,
	output logic [7:0]       o_torque_phase_control,
	output logic [7:0]       o_speed_constant,
	output logic [15:0]      o_coil_current_cmd,
	output logic [5:0]       o_converter_control,
	output logic [7:0]       o_factory_test,
	output logic             o_serial_edge_select
);

	// ************************************************************
	// State types
	// ************************************************************

	// Core-domain register file and its read views
	typedef struct packed {
		logic [NUM_REGS-1:0][7:0] regs;
		logic [7:0]               status;
		logic [9:0]               adc;
		logic                     seen_tog;
		logic                     only_one;
		logic                     only_two;
	} core_s;

	// Link-domain frame state, cleared while the select is idle
	typedef struct packed {
		link_phase_e phase;
		logic [4:0]  cnt;
		logic [7:0]  hdr;
		logic [7:0]  sh;
	} frame_s;

	// Link-domain commit holding, survives the end of a frame
	typedef struct packed {
		logic       tog;
		logic [3:0] addr;
		logic [7:0] data;
	} commit_s;

	core_s   core_r;
	core_s   core_nxt;
	frame_s  frame_r;
	frame_s  frame_nxt;
	commit_s commit_r;
	commit_s commit_nxt;

	logic                  link_clk;
	logic                  frame_rstn;
	logic [SYNC_WIDTH-1:0] sync_in;
	logic [SYNC_WIDTH-1:0] sync_out;
	logic [7:0]            hdr_full;
	logic [7:0]            rd_word;
	logic                  commit_now;
	logic                  drive_en;

	// ************************************************************
	// Link clock selection
	// ************************************************************

	// Sampling edge is the falling serial edge by default and the
	// rising one when the edge select bit is set; the select flips
	// only after a write's last edge, when the frame sits in its
	// done phase or is already held clear, so a stray edge then changes nothing
	assign link_clk = i_serial_clk ^ ~core_r.regs[ADDR_ENABLES][EP_EDGE_BIT];

	// Frame logic is held clear whenever the select is high, so
	// a frame cut short never leaves a half-built header behind
	assign frame_rstn = i_rstn & ~i_serial_select_n;

	// ************************************************************
	// Read view of the bank
	// ************************************************************

	// Header as it stands once the current bit is shifted in
	assign hdr_full = {frame_r.hdr[6:0], i_serial_io};

	// Word sampled at the eighth edge; the register slots only change from
	// writes of this same link, but the status and converter views follow their inputs every core cycle
	always_comb begin
		rd_word = core_r.regs[hdr_full[3:0]];
		unique case (hdr_full[3:0])
			ADDR_STATUS: begin
				rd_word = core_r.status;
			end
			ADDR_ADC_HIGH: begin
				rd_word = core_r.adc[9:2];
			end
			ADDR_ADC_CTRL: begin
				rd_word = {core_r.adc[1:0], core_r.regs[ADDR_ADC_CTRL][5:0]};
			end
			default: begin
				rd_word = core_r.regs[hdr_full[3:0]];
			end
		endcase
	end

	// ************************************************************
	// Link frame logic
	// ************************************************************

	// Sixteenth edge of a write frame carrying our identity
	assign commit_now = (frame_r.phase == PH_WRITE)
		&& (frame_r.cnt == FRAME_LAST_EDGE)
		&& (frame_r.hdr[6:4] == CHIP_ID);

	// Frame sequencer: direction, identity, address, then data
	always_comb begin
		frame_nxt = frame_r;
		if (frame_r.cnt != FRAME_EDGES) begin
			frame_nxt.cnt = frame_r.cnt + 5'h01;
		end
		unique case (frame_r.phase)
			PH_HEADER: begin
				frame_nxt.hdr = hdr_full;
				if (frame_r.cnt == HDR_LAST_EDGE) begin
					if (!hdr_full[7]) begin
						frame_nxt.phase = PH_WRITE;
					end else if (hdr_full[6:4] == CHIP_ID) begin
						frame_nxt.phase = PH_READ;
						frame_nxt.sh    = rd_word;
					end else begin
						frame_nxt.phase = PH_DONE;
					end
				end
			end
			PH_WRITE: begin
				frame_nxt.sh = {frame_r.sh[6:0], i_serial_io};
				if (frame_r.cnt == FRAME_LAST_EDGE) begin
					frame_nxt.phase = PH_DONE;
				end
			end
			PH_READ: begin
				// Next bit appears on the edge the host samples on
				frame_nxt.sh = {frame_r.sh[6:0], 1'b0};
				if (frame_r.cnt == FRAME_LAST_EDGE) begin
					frame_nxt.phase = PH_DONE;
				end
			end
			PH_DONE: begin
				frame_nxt.sh = frame_r.sh;
			end
		endcase
	end

	always_ff @(posedge link_clk or negedge frame_rstn) begin
		if (!frame_rstn) begin
			frame_r <= '{phase: PH_HEADER, default: '0};
		end else begin
			frame_r <= frame_nxt;
		end
	end

	// Commit holding: address and data stay put until the next
	// commit, so the core reads them well after the toggle settles
	always_comb begin
		commit_nxt = commit_r;
		if (commit_now) begin
			commit_nxt.tog  = ~commit_r.tog;
			commit_nxt.addr = frame_r.hdr[3:0];
			commit_nxt.data = {frame_r.sh[6:0], i_serial_io};
		end
	end

	always_ff @(posedge link_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			commit_r <= '0;
		end else begin
			commit_r <= commit_nxt;
		end
	end

	// ************************************************************
	// Data pin
	// ************************************************************

	// Turnaround half a cycle after the last address bit
	serial_turnaround u_turnaround (
		.i_link_clk   (link_clk),
		.i_frame_rstn (frame_rstn),
		.i_drive_req  (frame_r.phase == PH_READ),
		.o_drive_en   (drive_en)
	);

	assign o_serial_io    = frame_r.sh[7];
	assign o_serial_io_oe = drive_en;

	// ************************************************************
	// Crossings into the core domain
	// ************************************************************

	// Detector levels, converter result and the commit toggle
	assign sync_in = {
		commit_r.tog,
		i_adc_result,
		i_spindle_current_polarity,
		i_coil_cal_comparator,
		i_speed_sync_fault,
		i_thermal_trip_flag,
		i_thermal_warning_flag
	};

	bit_sync #(
		.WIDTH (SYNC_WIDTH)
	) u_sync (
		.i_clk   (i_core_clk),
		.i_rstn  (i_rstn),
		.i_async (sync_in),
		.o_sync  (sync_out)
	);

	// ************************************************************
	// Core register file
	// ************************************************************

	// Status refresh every cycle and commit of link writes
	always_comb begin
		core_nxt          = core_r;
		core_nxt.seen_tog = sync_out[15];
		core_nxt.adc      = sync_out[14:5];

		// Revision is a constant, no write path reaches it
		core_nxt.status[2:0]          = REVISION;
		core_nxt.status[STAT_WARN_BIT]  = sync_out[0];
		core_nxt.status[STAT_TRIP_BIT]  = sync_out[1];
		core_nxt.status[STAT_FAULT_BIT] = sync_out[2];
		core_nxt.status[STAT_POL_BIT]   = sync_out[4];

		// Comparator only means something during calibration
		if (core_r.regs[ADDR_MOTOR][MS_VCM_LSB +: 3] == VCM_STATE_CAL) begin
			core_nxt.status[STAT_CAL_BIT] = sync_out[3];
		end else begin
			core_nxt.status[STAT_CAL_BIT] = 1'b0;
		end

		// One write per toggle change; read-only slots refuse it
		if (sync_out[15] != core_r.seen_tog) begin
			if ((commit_r.addr != ADDR_STATUS)
				&& (commit_r.addr != ADDR_ADC_HIGH)) begin
				core_nxt.regs[commit_r.addr] = commit_r.data;
			end
		end

		// Threshold field decodes to the two exclusive phases
		core_nxt.only_one = core_nxt.regs[ADDR_RETRACT][RU_THRESH_LSB +: 3]
			== THRESH_ONLY_ONE;
		core_nxt.only_two = core_nxt.regs[ADDR_RETRACT][RU_THRESH_LSB +: 3]
			== THRESH_ONLY_TWO;
	end

	// All locations start cleared
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			core_r <= '0;
		end else begin
			core_r <= core_nxt;
		end
	end

	// ************************************************************
	// Field outputs
	// ************************************************************

	// Retract and unload configuration
	assign o_active_brake_disable   = core_r.regs[ADDR_RETRACT][RU_BRAKE_BIT];
	assign o_unload_phase_threshold = core_r.regs[ADDR_RETRACT][RU_THRESH_LSB +: 3];
	assign o_unload_phase_one       = core_r.only_one;
	assign o_unload_phase_two       = core_r.only_two;
	assign o_phase_two_unload_level = core_r.regs[ADDR_RETRACT][RU_LEVEL2_LSB +: 2];
	assign o_phase_one_unload_level = core_r.regs[ADDR_RETRACT][RU_LEVEL1_LSB +: 2];

	// Trim stays two's complement for the analog decoder
	assign o_retract_trim      = core_r.regs[ADDR_CALIB][RC_TRIM_LSB +: 4];
	assign o_calib_shock_upper = core_r.regs[ADDR_CALIB][RC_UPPER_LSB +: 4];

	// Motor, spindle and converter control
	assign o_motor_state_select    = core_r.regs[ADDR_MOTOR];
	assign o_spindle_drive_control = core_r.regs[ADDR_SPINDLE];
	assign o_enables_and_protocol  = core_r.regs[ADDR_ENABLES];
	assign o_clock_prescale_window = core_r.regs[ADDR_PRESCALE];
	assign o_torque_phase_control  = core_r.regs[ADDR_TORQUE];
	assign o_speed_constant        = core_r.regs[ADDR_SPEED];
	assign o_coil_current_cmd      = {core_r.regs[ADDR_CMD_HIGH], core_r.regs[ADDR_CMD_LOW]};
	assign o_converter_control     = core_r.regs[ADDR_ADC_CTRL][CC_CTRL_WIDTH-1:0];
	assign o_factory_test          = core_r.regs[ADDR_TEST];
	assign o_serial_edge_select    = core_r.regs[ADDR_ENABLES][EP_EDGE_BIT];

endmodule

/* sim/motor_bank_properties.sv */
// Port-level checks of the motor driver register bank
`timescale 1ns/1ps
module motor_bank_properties
	import motor_bank_pkg::*;
(
	// Clocks and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_serial_clk,
	// Link
	input  wire logic        i_serial_select_n,
	input  wire logic        o_serial_io_oe,
	// Register outputs
	input  wire logic        o_active_brake_disable,
	input  wire logic [2:0]  o_unload_phase_threshold,
	input  wire logic        o_unload_phase_one,
	input  wire logic        o_unload_phase_two,
	input  wire logic [3:0]  o_retract_trim,
	input  wire logic [7:0]  o_enables_and_protocol,
	input  wire logic [7:0]  o_speed_constant,
	input  wire logic [15:0] o_coil_current_cmd,
	input  wire logic        o_serial_edge_select
);
	logic [3:0]  quiet_r;
	logic [3:0]  quiet_nxt;
	logic [31:0] regs;

	// Registers that may only move just after a frame
	assign regs = {o_active_brake_disable, o_unload_phase_threshold, o_retract_trim,
		o_speed_constant, o_coil_current_cmd};

	// Core cycles since the link was last selected, saturating
	always_comb begin
		quiet_nxt = quiet_r;
		if (!i_serial_select_n) quiet_nxt = 4'h0;
		else if (quiet_r != 4'hf) quiet_nxt = quiet_r + 4'h1;
	end
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) quiet_r <= 4'h0;
		else quiet_r <= quiet_nxt;
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	// Threshold code held for two cycles, so the decode has settled
	sequence s_thr(logic [2:0] v);
		(o_unload_phase_threshold == v) [*2];
	endsequence

	AST_PHASE_ONE: assert property (s_thr(3'h0) |-> o_unload_phase_one && !o_unload_phase_two)
		else $error("phase one decode wrong");
	AST_PHASE_TWO: assert property (s_thr(3'h7) |-> o_unload_phase_two && !o_unload_phase_one)
		else $error("phase two decode wrong");
	AST_PHASE_MID: assert property ((o_unload_phase_threshold inside {[3'h1:3'h6]}) [*2]
		|-> !o_unload_phase_one && !o_unload_phase_two)
		else $error("mid threshold selects a single phase");
	AST_RESET_CLEAR: assert property (disable iff (1'b0) !i_rstn |-> regs == 32'h0
		&& !o_unload_phase_one && !o_unload_phase_two && !o_serial_io_oe)
		else $error("outputs not clear in reset");
	AST_QUIET_HOLD: assert property ($changed(regs) |-> quiet_r < 4'h8)
		else $error("register moved without a frame");
	AST_EDGE_FOLLOW: assert property ($changed(o_serial_edge_select)
		|-> (o_serial_edge_select == o_enables_and_protocol[7]) && (quiet_r < 4'h8))
		else $error("edge select moved without a write frame");
	AST_OE_IDLE: assert property (i_serial_select_n [*2] |-> !o_serial_io_oe)
		else $error("pin driven while deselected");
	AST_OE_SELECT: assert property (@(posedge i_serial_clk) i_serial_select_n |-> !o_serial_io_oe)
		else $error("pin driven outside a frame");
endmodule

/* sim/serial_host_model.sv */
// Behavioural host controller on the three-wire serial link
`timescale 1ns/1ps
module serial_host_model
	import motor_bank_pkg::*;
(
	// Device side of the data pin
	input  wire logic i_dev_io,
	input  wire logic i_dev_oe,
	// Link lines
	output logic      o_serial_clk,
	output logic      o_serial_select_n,
	output logic      o_line
);
	logic host_oe;
	logic host_do;
	logic filler;

	// Released pin toggles so a stale level never reads as data
	assign o_line = i_dev_oe ? i_dev_io : (host_oe ? host_do : filler);

	initial begin
		o_serial_clk      = 1'b1;
		o_serial_select_n = 1'b1;
		host_oe           = 1'b0;
		host_do           = 1'b0;
		filler            = 1'b0;
	end

	// One frame, MSB first: rw, id, address, data; fewer bits cut it short
	task automatic frame(input logic [15:0] word, input logic es, input int nbits,
		output logic [7:0] rdata);
		rdata = 8'h00;
		o_serial_clk = ~es;
		#30 o_serial_select_n = 1'b0;
		for (int k = 1; k <= nbits; k++) begin
			host_oe = !(word[15] && k > 8);
			host_do = word[16-k];
			filler = ~filler;
			#39 if (k > 8) rdata = {rdata[6:0], o_line};
			#1 o_serial_clk = es;
			#40 o_serial_clk = ~es;
		end
		#20 o_serial_select_n = 1'b1;
		host_oe = 1'b0;
		#250;
	endtask
endmodule

/* sim/tb_motor_driver_register_bank.sv */
// Self-checking testbench of the motor driver register bank
`timescale 1ns/1ps
module tb_motor_driver_register_bank;
	import motor_bank_pkg::*;
	logic i_core_clk, i_rstn, i_serial_clk, i_serial_select_n, i_serial_io;
	logic i_thermal_warning_flag, i_thermal_trip_flag, i_speed_sync_fault;
	logic i_coil_cal_comparator, i_spindle_current_polarity;
	logic [9:0] i_adc_result;
	logic o_serial_io, o_serial_io_oe, o_active_brake_disable, o_unload_phase_one;
	logic o_unload_phase_two, o_serial_edge_select;
	logic [1:0] o_phase_two_unload_level, o_phase_one_unload_level;
	logic [2:0] o_unload_phase_threshold;
	logic [3:0] o_retract_trim, o_calib_shock_upper;
	logic [7:0] o_motor_state_select, o_spindle_drive_control, o_enables_and_protocol;
	logic [7:0] o_clock_prescale_window, o_torque_phase_control, o_speed_constant;
	logic [7:0] o_factory_test;
	logic [5:0] o_converter_control;
	logic [15:0] o_coil_current_cmd;
	int mismatches = 0;
	int samples_checked = 0;
	int oe_hits = 0;
	logic es;
	logic [7:0] shadow [16];

	motor_driver_register_bank motor_driver_register_bank_i (.i_core_clk, .i_rstn,
		.i_serial_clk, .i_serial_select_n, .i_serial_io, .o_serial_io, .o_serial_io_oe,
		.i_thermal_warning_flag, .i_thermal_trip_flag, .i_speed_sync_fault,
		.i_coil_cal_comparator, .i_spindle_current_polarity, .i_adc_result,
		.o_active_brake_disable, .o_unload_phase_threshold, .o_unload_phase_one,
		.o_unload_phase_two, .o_phase_two_unload_level, .o_phase_one_unload_level,
		.o_retract_trim, .o_calib_shock_upper, .o_motor_state_select,
		.o_spindle_drive_control, .o_enables_and_protocol, .o_clock_prescale_window,
		.o_torque_phase_control, .o_speed_constant, .o_coil_current_cmd,
		.o_converter_control, .o_factory_test, .o_serial_edge_select);
	serial_host_model serial_host_model_i (.i_dev_io(o_serial_io), .i_dev_oe(o_serial_io_oe),
		.o_serial_clk(i_serial_clk), .o_serial_select_n(i_serial_select_n),
		.o_line(i_serial_io));

	// ************************************************************
	// Shared tasks
	// ************************************************************
	initial begin
		i_core_clk = 1'b0;
		forever #12.5 i_core_clk = ~i_core_clk;
	end
	always @(posedge o_serial_io_oe) oe_hits++;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		if (mismatches == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic xfer(input logic rw, input logic [2:0] id, input logic [3:0] a,
		input logic [7:0] d, input int n, output logic [7:0] r);
		serial_host_model_i.frame({rw, id, a, d}, es, n, r);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] r;
		xfer(1'b0, CHIP_ID_DEF, a, d, 16, r);
		if (a != ADDR_STATUS && a != ADDR_ADC_HIGH) shadow[a] = d;
	endtask
	task automatic rd_chk(input logic [3:0] a);
		logic [7:0] r;
		logic [7:0] e;
		e = shadow[a];
		if (a == ADDR_ADC_HIGH) e = i_adc_result[9:2];
		if (a == ADDR_ADC_CTRL) e = {i_adc_result[1:0], shadow[a][5:0]};
		xfer(1'b1, CHIP_ID_DEF, a, 8'h00, 16, r);
		check(r, e);
	endtask
	task automatic st_chk(input logic [7:0] e);
		logic [7:0] r;
		xfer(1'b1, CHIP_ID_DEF, ADDR_STATUS, 8'h00, 16, r);
		check(r, e);
	endtask
	function automatic logic [7:0] out_of(input logic [3:0] a);
		case (a)
			4'h1: return {o_phase_one_unload_level, o_phase_two_unload_level,
				o_unload_phase_threshold, o_active_brake_disable};
			4'h2: return {o_calib_shock_upper, o_retract_trim};
			4'h3: return o_motor_state_select;
			4'h4: return o_spindle_drive_control;
			4'h5: return o_enables_and_protocol;
			4'h6: return o_clock_prescale_window;
			4'h7: return o_torque_phase_control;
			4'h8: return o_speed_constant;
			4'h9: return o_coil_current_cmd[15:8];
			4'ha: return o_coil_current_cmd[7:0];
			4'hc: return {2'h0, o_converter_control};
			4'hf: return o_factory_test;
			default: return 8'h00;
		endcase
	endfunction

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset;
		for (int a = 1; a < 16; a++) check(out_of(a[3:0]), 16'h0000);
		check(o_unload_phase_one, 1'b1);
		st_chk({5'h00, REVISION_DEF});
	endtask
	task automatic t_fields;
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_RETRACT, {c[1:0], ~c[1:0], c[2:0], c[0]});
			check({o_unload_phase_one, o_unload_phase_two}, {c == 0, c == 7});
			check(out_of(ADDR_RETRACT), shadow[1]);
		end
		wr(ADDR_CALIB, 8'h07);
		check(o_retract_trim, 4'h7);
		wr(ADDR_CALIB, 8'h98);
		check({o_calib_shock_upper, o_retract_trim}, 8'h98);
	endtask
	task automatic t_write_all;
		for (int a = 1; a < 16; a++) wr(a[3:0], {1'b0, a[2:0], a[3:0]} ^ 8'h5a);
		for (int a = 1; a < 16; a++) begin
			if (a == 12) check(out_of(4'hc), {2'h0, shadow[12][5:0]});
			else if (a != 11 && a != 13 && a != 14) check(out_of(a[3:0]), shadow[a]);
			rd_chk(a[3:0]);
		end
	endtask
	task automatic t_readonly;
		wr(ADDR_STATUS, 8'hff);
		@(negedge i_core_clk);
		i_adc_result = 10'h1a5;
		wr(ADDR_ADC_HIGH, 8'hff);
		rd_chk(ADDR_ADC_HIGH);
		rd_chk(ADDR_ADC_CTRL);
		st_chk({5'h00, REVISION_DEF});
	endtask
	task automatic t_status;
		logic [4:0] pat;
		for (int p = 0; p < 4; p++) begin
			pat = p[0] ? 5'h15 : 5'h0a;
			@(negedge i_core_clk);
			{i_spindle_current_polarity, i_coil_cal_comparator, i_speed_sync_fault,
				i_thermal_trip_flag, i_thermal_warning_flag} = pat;
			wr(ADDR_MOTOR, p[1] ? 8'h50 : 8'h60);
			st_chk({pat[4], pat[3] & p[1], pat[2:0], REVISION_DEF});
		end
	endtask
	task automatic t_cut;
		logic [7:0] r;
		int hits;
		hits = oe_hits;
		xfer(1'b0, CHIP_ID_DEF, ADDR_SPEED, 8'hee, 15, r);
		xfer(1'b0, ~CHIP_ID_DEF, ADDR_SPEED, 8'hee, 16, r);
		xfer(1'b1, ~CHIP_ID_DEF, ADDR_SPEED, 8'h00, 16, r);
		check(o_speed_constant, shadow[8]);
		check(16'(oe_hits - hits), 16'h0000);
	endtask
	task automatic t_edge;
		wr(ADDR_ENABLES, 8'h80);
		check(o_serial_edge_select, 1'b1);
		es = 1'b1;
		rd_chk(ADDR_ENABLES);
		wr(ADDR_SPEED, 8'hc3);
		rd_chk(ADDR_SPEED);
		wr(ADDR_ENABLES, 8'h00);
		check(o_serial_edge_select, 1'b0);
		es = 1'b0;
		rd_chk(ADDR_SPEED);
	endtask

	initial begin
		i_rstn = 1'b0;
		{i_spindle_current_polarity, i_coil_cal_comparator, i_speed_sync_fault,
			i_thermal_trip_flag, i_thermal_warning_flag} = 5'h00;
		i_adc_result = 10'h2d6;
		es = 1'b0;
		foreach (shadow[i]) shadow[i] = 8'h00;
		repeat (6) @(negedge i_core_clk);
		i_rstn = 1'b1;
		repeat (4) @(negedge i_core_clk);
		t_reset;
		t_fields;
		t_write_all;
		t_readonly;
		t_status;
		t_cut;
		t_edge;
		give_verdict;
	end
	// Watchdog, well beyond the roughly 60 frames of the run
	initial begin
		#300us;
		mismatches++;
		give_verdict;
	end
endmodule

bind motor_driver_register_bank motor_bank_properties motor_bank_properties_i (.i_core_clk,
	.i_rstn, .i_serial_clk, .i_serial_select_n, .o_serial_io_oe, .o_active_brake_disable,
	.o_unload_phase_threshold, .o_unload_phase_one, .o_unload_phase_two, .o_retract_trim,
	.o_enables_and_protocol, .o_speed_constant, .o_coil_current_cmd, .o_serial_edge_select);
